// ---- hdl/smbus_slave_alert_port.sv ----
/*
 * smbus_slave_alert_port: serial slave port with write byte, read byte,
 * receive byte, broadcast write, alert response and open-drain alert line.
 * assumes: i_link_clk free-running and much faster than the bus clock;
 * i_events are pulses from logic on i_clk; pins are wired-and outside.
 */
// Operation
// - hold data low for the whole acknowledge clock pulse when acknowledging
// - write starts with start, address and direction 0; ack only on match
// - command byte low five bits load the pointer, upper three ignored
// - data byte after the command is acknowledged and stored at the pointer; the code stores it only for the mask and port control pointers
// - pointer returns to zero on every stop
// - register read: write address, command, repeated start, read address
// - read straight after start returns the event register at pointer zero
// - alert response acknowledged only while driving alert; sends own address and 1
// - own address is fixed 010 followed by the four address select levels
// - during alert response a sent 1 read back as 0 aborts the transfer
// - a completed alert response releases the alert line
// - after release, alert stays off until its cause is cleared
// - cause cleared by clear-on-read of events or clear-all bit
// - alert line changes only between stop and the next start
// - each mask bit lets the matching event bit raise the alert
// - broadcast address writes are accepted as well as the own address
`timescale 1ns/10ps
module smbus_slave_alert_port
	import smbus_slave_alert_pkg::*;
(
	// core clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// link clock
	input wire logic i_link_clk,
	// serial bus pins
	input wire logic i_scl,
	input wire logic i_serial_data_input,
	output logic o_serial_data_output,
	output logic o_alert_oe,
	// straps
	input wire logic [SEL_W-1:0] i_address_select_pins,
	// port logic side
	input wire logic [BYTE_W-1:0] i_events,
	output logic [BYTE_W-1:0] o_port_ctrl
);

	typedef struct packed {
		logic [BYTE_W-1:0] tog;
	} core_s;

	typedef struct packed {
		logic scl1;
		logic scl2;
		logic scl3;
		logic sda1;
		logic sda2;
		logic sda3;
		logic [SEL_W-1:0] ad1;
		logic [SEL_W-1:0] ad2;
		logic [BYTE_W-1:0] ev1;
		logic [BYTE_W-1:0] ev2;
		logic [BYTE_W-1:0] ev3;
		bus_state_e st;
		logic [CNT_W-1:0] cnt;
		logic ack;
		logic mack;
		logic [BYTE_W-1:0] sh;
		logic [BYTE_W-1:0] tx;
		logic [PTR_W-1:0] ptr;
		logic drive;
		logic busy;
		logic [BYTE_W-1:0] events;
		logic [BYTE_W-1:0] mask;
		logic [BYTE_W-1:0] ctrl;
		logic inhibit;
		logic alert;
	} link_s;

	core_s core_reg;
	core_s core_next;
	link_s link_reg;
	link_s link_next;

	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic [BYTE_W-1:0] clr;
	logic [BYTE_W-1:0] rd;

	function automatic logic [BYTE_W-1:0] reg_read(
		input logic [PTR_W-1:0] ptr,
		input logic [BYTE_W-1:0] events,
		input logic [BYTE_W-1:0] mask,
		input logic [BYTE_W-1:0] ctrl
	);
		logic [BYTE_W-1:0] v;
		v = READ_ZERO;
		if (ptr == REG_EVENTS || ptr == REG_EVENTS_COR) begin
			v = events;
		end else if (ptr == REG_MASK) begin
			v = mask;
		end else if (ptr == REG_PORT_CTRL) begin
			v = ctrl;
		end
		return v;
	endfunction : reg_read

	// core side: each event pulse flips a toggle that crosses to the link
	always_comb begin
		core_next = core_reg;
		core_next.tog = core_reg.tog ^ i_events;
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			core_reg <= '0;
		end else begin
			core_reg <= core_next;
		end
	end

	// bus conditions from the second and third sync stages
	assign rise = link_reg.scl2 & ~link_reg.scl3;
	assign fall = ~link_reg.scl2 & link_reg.scl3;
	assign start = link_reg.scl2 & link_reg.scl3 & link_reg.sda3 & ~link_reg.sda2;
	assign stop = link_reg.scl2 & link_reg.scl3 & ~link_reg.sda3 & link_reg.sda2;
	assign rd = reg_read(link_reg.ptr, link_reg.events, link_reg.mask, link_reg.ctrl);

	always_comb begin
		logic [6:0] own;
		logic cause;
		own = {OWN_ADDR_HI, link_reg.ad2};
		cause = |(link_reg.events & link_reg.mask);
		clr = '0;
		link_next = link_reg;
		link_next.scl1 = i_scl;
		link_next.scl2 = link_reg.scl1;
		link_next.scl3 = link_reg.scl2;
		link_next.sda1 = i_serial_data_input;
		link_next.sda2 = link_reg.sda1;
		link_next.sda3 = link_reg.sda2;
		link_next.ad1 = i_address_select_pins;
		link_next.ad2 = link_reg.ad1;
		link_next.ev1 = core_reg.tog;
		link_next.ev2 = link_reg.ev1;
		link_next.ev3 = link_reg.ev2;
		if (!cause) begin
			link_next.inhibit = 1'b0;
		end
		if (!link_reg.busy) begin
			link_next.alert = cause & ~link_reg.inhibit;
		end
		if (start) begin
			link_next.st = ST_ADDR;
			link_next.cnt = '0;
			link_next.ack = 1'b0;
			link_next.mack = 1'b0;
			link_next.drive = 1'b0;
			link_next.busy = 1'b1;
		end else if (stop) begin
			link_next.st = ST_IDLE;
			link_next.ptr = '0;
			link_next.ack = 1'b0;
			link_next.mack = 1'b0;
			link_next.drive = 1'b0;
			link_next.busy = 1'b0;
		end else if (rise && !link_reg.ack) begin
			if (link_reg.st == ST_ADDR || link_reg.st == ST_CMD || link_reg.st == ST_WDATA) begin
				if (link_reg.cnt < BIT_ACK) begin
					link_next.sh = {link_reg.sh[BYTE_W-2:0], link_reg.sda2};
					link_next.cnt = link_reg.cnt + CNT_STEP;
				end
			end else if (link_reg.st == ST_READ || link_reg.st == ST_ARA) begin
				if (link_reg.mack) begin
					if (link_reg.sda2) begin
						link_next.st = ST_IGNORE;
						link_next.mack = 1'b0;
					end
				end else if (link_reg.cnt < BIT_ACK) begin
					link_next.cnt = link_reg.cnt + CNT_STEP;
					if (link_reg.st == ST_ARA && link_reg.tx[BYTE_W-1] && !link_reg.sda2) begin
						link_next.st = ST_IGNORE;
						link_next.drive = 1'b0;
					end
				end
			end
		end else if (fall) begin
			if (link_reg.mack) begin
				link_next.mack = 1'b0;
				link_next.cnt = '0;
				link_next.tx = rd;
				link_next.drive = ~rd[BYTE_W-1];
			end else if (link_reg.ack) begin
				link_next.ack = 1'b0;
				link_next.cnt = '0;
				link_next.drive = 1'b0;
				if (link_reg.st == ST_ARA) begin
					link_next.tx = {own, RW_READ};
					link_next.drive = ~own[6];
				end else if (link_reg.st == ST_READ) begin
					link_next.tx = rd;
					link_next.drive = ~rd[BYTE_W-1];
					if (link_reg.ptr == REG_EVENTS_COR) begin
						clr = link_reg.events;
					end
				end
			end else if (link_reg.cnt == BIT_ACK) begin
				case (link_reg.st)
					ST_ADDR: begin
						if (link_reg.sh[7:1] == own
							|| (link_reg.sh[7:1] == BCAST_ADDR && !link_reg.sh[0])) begin
							link_next.ack = 1'b1;
							link_next.drive = 1'b1;
							link_next.st = link_reg.sh[0] ? ST_READ : ST_CMD;
						end else if (link_reg.sh[7:1] == ARA_ADDR && link_reg.sh[0]
							&& link_reg.alert) begin
							link_next.ack = 1'b1;
							link_next.drive = 1'b1;
							link_next.st = ST_ARA;
						end else begin
							link_next.st = ST_IGNORE;
						end
					end
					ST_CMD: begin
						link_next.ptr = link_reg.sh[PTR_W-1:0];
						link_next.ack = 1'b1;
						link_next.drive = 1'b1;
						link_next.st = ST_WDATA;
					end
					ST_WDATA: begin
						link_next.ack = 1'b1;
						link_next.drive = 1'b1;
						if (link_reg.ptr == REG_MASK) begin
							link_next.mask = link_reg.sh;
						end else if (link_reg.ptr == REG_PORT_CTRL) begin
							link_next.ctrl = link_reg.sh;
						end else if (link_reg.ptr == REG_IRQ_CLR) begin
							if (link_reg.sh[CLR_ALL_BIT]) begin
								clr = '1;
							end
							if (link_reg.sh[REL_ALERT_BIT]) begin
								link_next.inhibit = 1'b1;
							end
						end
					end
					ST_READ: begin
						link_next.drive = 1'b0;
						link_next.mack = 1'b1;
					end
					ST_ARA: begin
						link_next.drive = 1'b0;
						link_next.inhibit = 1'b1;
						link_next.st = ST_IGNORE;
					end
					default: begin
						link_next.drive = 1'b0;
					end
				endcase
			end else if ((link_reg.st == ST_READ || link_reg.st == ST_ARA)
				&& link_reg.cnt != '0) begin
				link_next.tx = {link_reg.tx[BYTE_W-2:0], 1'b0};
				link_next.drive = ~link_reg.tx[BYTE_W-2];
			end
		end
		// a new event wins over a clear in the same cycle
		link_next.events = (link_reg.events & ~clr) | (link_reg.ev2 ^ link_reg.ev3);
	end

	always_ff @(posedge i_link_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			link_reg <= '0;
			link_reg.scl1 <= 1'b1;
			link_reg.scl2 <= 1'b1;
			link_reg.scl3 <= 1'b1;
			link_reg.sda1 <= 1'b1;
			link_reg.sda2 <= 1'b1;
			link_reg.sda3 <= 1'b1;
			link_reg.mask <= MASK_RST;
			link_reg.ctrl <= CTRL_RST;
		end else begin
			link_reg <= link_next;
		end
	end

	assign o_serial_data_output = link_reg.drive;
	assign o_alert_oe = link_reg.alert;
	assign o_port_ctrl = link_reg.ctrl;

	// checks on the link domain
	property p_ack_stable;
		@(posedge i_link_clk) disable iff (!i_nrst)
		(link_reg.ack && link_reg.scl2 && link_reg.scl3 && !start && !stop)
			|=> $stable(link_reg.drive);
	endproperty
	a_ack_stable: assert property (p_ack_stable) else $error("ack drive moved");

	property p_ptr_stop;
		@(posedge i_link_clk) disable iff (!i_nrst)
		stop |=> (link_reg.ptr == '0) && (link_reg.st == ST_IDLE);
	endproperty
	a_ptr_stop: assert property (p_ptr_stop) else $error("pointer not cleared at stop");

	property p_cmd_ptr;
		@(posedge i_link_clk) disable iff (!i_nrst)
		(fall && !start && !stop && !link_reg.ack && link_reg.st == ST_CMD
			&& link_reg.cnt == BIT_ACK)
			|=> link_reg.ptr == $past(link_reg.sh[PTR_W-1:0]) && link_reg.drive;
	endproperty
	a_cmd_ptr: assert property (p_cmd_ptr) else $error("command not latched");

	property p_foreign;
		@(posedge i_link_clk) disable iff (!i_nrst)
		(link_reg.st == ST_IGNORE && !link_reg.drive) |=> !link_reg.drive;
	endproperty
	a_foreign: assert property (p_foreign) else $error("drove line for foreign address");

	property p_alert_idle;
		@(posedge i_link_clk) disable iff (!i_nrst)
		!$stable(link_reg.alert) |-> !$past(link_reg.busy);
	endproperty
	a_alert_idle: assert property (p_alert_idle) else $error("alert moved mid transfer");

	property p_ara_alerting;
		@(posedge i_link_clk) disable iff (!i_nrst)
		(link_reg.st == ST_ADDR) ##1 (link_reg.st == ST_ARA) |-> $past(link_reg.alert);
	endproperty
	a_ara_alerting: assert property (p_ara_alerting) else $error("ara ack without alert");

	property p_arb_lost;
		@(posedge i_link_clk) disable iff (!i_nrst)
		(rise && !start && !link_reg.ack && !link_reg.mack && link_reg.st == ST_ARA
			&& link_reg.cnt < BIT_ACK && link_reg.tx[BYTE_W-1] && !link_reg.sda2)
			|=> (link_reg.st == ST_IGNORE && !link_reg.drive) [*2];
	endproperty
	a_arb_lost: assert property (p_arb_lost) else $error("arbitration loss ignored");

	property p_ara_release;
		@(posedge i_link_clk) disable iff (!i_nrst)
		(fall && !start && !stop && !link_reg.ack && !link_reg.mack
			&& link_reg.st == ST_ARA && link_reg.cnt == BIT_ACK)
			|=> link_reg.inhibit ##1 (!link_reg.busy || link_reg.alert == $past(link_reg.alert));
	endproperty
	a_ara_release: assert property (p_ara_release) else $error("alert not released");

	property p_ara_addr;
		@(posedge i_link_clk) disable iff (!i_nrst)
		(fall && !start && !stop && link_reg.ack && link_reg.st == ST_ARA)
			|=> link_reg.tx == {OWN_ADDR_HI, link_reg.ad2, RW_READ};
	endproperty
	a_ara_addr: assert property (p_ara_addr) else $error("wrong alert response address");

	property p_clear_all;
		@(posedge i_link_clk) disable iff (!i_nrst)
		(clr == '1 && (link_reg.ev2 == link_reg.ev3)) |=> link_reg.events == '0;
	endproperty
	a_clear_all: assert property (p_clear_all) else $error("events not cleared");

	c_write: cover property (@(posedge i_link_clk) disable iff (!i_nrst)
		link_reg.st == ST_WDATA && link_reg.ack ##[1:1000] stop);
	c_read: cover property (@(posedge i_link_clk) disable iff (!i_nrst)
		link_reg.st == ST_READ && link_reg.mack ##[1:1000] stop);
	c_ara_won: cover property (@(posedge i_link_clk) disable iff (!i_nrst)
		link_reg.st == ST_ARA ##1 link_reg.st == ST_IGNORE && link_reg.inhibit);
	c_arb_lost: cover property (@(posedge i_link_clk) disable iff (!i_nrst)
		link_reg.st == ST_ARA && rise && link_reg.tx[BYTE_W-1] && !link_reg.sda2);

endmodule : smbus_slave_alert_port

// ---- hdl/smbus_slave_alert_pkg.sv ----
/*
 * smbus_slave_alert_pkg: constants, register map and bus states of the
 * serial slave port with alert response.
 * assumes: compiled before the port module.
 */
package smbus_slave_alert_pkg;

	// bus addresses
	localparam logic [2:0] OWN_ADDR_HI = 3'h2;
	localparam logic [6:0] BCAST_ADDR = 7'h30;
	localparam logic [6:0] ARA_ADDR = 7'h0c;
	localparam logic RW_READ = 1'b1;

	// widths and bit counting
	localparam int BYTE_W = 8;
	localparam int PTR_W = 5;
	localparam int SEL_W = 4;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] BIT_ACK = 4'h8;
	localparam logic [CNT_W-1:0] CNT_STEP = 4'h1;

	// register offsets
	localparam logic [PTR_W-1:0] REG_EVENTS = 5'h00;
	localparam logic [PTR_W-1:0] REG_EVENTS_COR = 5'h01;
	localparam logic [PTR_W-1:0] REG_MASK = 5'h02;
	localparam logic [PTR_W-1:0] REG_PORT_CTRL = 5'h03;
	localparam logic [PTR_W-1:0] REG_IRQ_CLR = 5'h1a;

	// interrupt_clear_control fields
	localparam int CLR_ALL_BIT = 7;
	localparam int REL_ALERT_BIT = 6;

	// reset values and the value read at unmapped offsets
	localparam logic [BYTE_W-1:0] MASK_RST = 8'h00;
	localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;
	localparam logic [BYTE_W-1:0] READ_ZERO = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_CMD,
		ST_WDATA,
		ST_READ,
		ST_ARA,
		ST_IGNORE
	} bus_state_e;

endpackage : smbus_slave_alert_pkg

// ---- dv/smbus_host_model.sv ----
/*
 * smbus_host_model: bit-level bus master with acknowledge and arbitration stimulus.
 * assumes: data wire pulled up, low while either side pulls it low.
 */
`timescale 1ns/10ps
module smbus_host_model (
	// bus pins
	output logic o_scl,
	output logic o_sda_low,
	input wire logic i_sda
);
	localparam int QTR = 150;
	int unstable;

	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
		unstable = 0;
	end

	// start or repeated start
	task start_cond;
		o_sda_low = 1'b0;
		#QTR o_scl = 1'b1;
		#QTR o_sda_low = 1'b1;
		#QTR o_scl = 1'b0;
		#QTR;
	endtask : start_cond

	task stop_cond;
		o_sda_low = 1'b1;
		#QTR o_scl = 1'b1;
		#QTR o_sda_low = 1'b0;
		#QTR;
	endtask : stop_cond

	// data level sampled twice over the high phase
	task xfer_bit(input logic b, output logic seen);
		logic early;
		o_sda_low = !b;
		#QTR o_scl = 1'b1;
		#(QTR/2) early = i_sda;
		#(QTR/2) seen = i_sda;
		if (early !== seen) unstable++;
		o_scl = 1'b0;
		#QTR;
	endtask : xfer_bit

	// eight bits msb first, then the acknowledge bit
	task xfer_byte(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
		output logic ack_rx);
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(tx[i], rx[i]);
		end
		xfer_bit(ack_tx, ack_rx);
	endtask : xfer_byte
endmodule : smbus_host_model

// ---- dv/testbench.sv ----
/*
 * testbench: random and corner transfers against the slave port with alert.
 * assumes: host model in dv/, package compiled first.
 */
`timescale 1ns/10ps
module testbench;
	import smbus_slave_alert_pkg::*;
	logic i_clk, i_nrst, link_clk, scl, sda_low, o_serial_data_output, o_alert_oe, ak;
	wire sda;
	logic [SEL_W-1:0] sel;
	logic [BYTE_W-1:0] ev, o_port_ctrl, rx, d, e;
	logic [6:0] own;
	int bad_count, checks;

	assign sda = !(sda_low || o_serial_data_output);

	smbus_host_model host_u (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));

	smbus_slave_alert_port dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_link_clk(link_clk),
		.i_scl(scl), .i_serial_data_input(sda), .o_serial_data_output(o_serial_data_output),
		.o_alert_oe(o_alert_oe), .i_address_select_pins(sel), .i_events(ev),
		.o_port_ctrl(o_port_ctrl));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	initial begin
		link_clk = 1'b0;
		#3.7;
		forever #6 link_clk = ~link_clk;
	end

	function automatic logic [7:0] ara_reply(input logic [SEL_W-1:0] s);
		return {OWN_ADDR_HI, s, 1'b1};
	endfunction : ara_reply

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task report_and_stop;
		if (bad_count == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] v,
		input logic acked);
		host_u.start_cond();
		host_u.xfer_byte({a, 1'b0}, 1'b1, rx, ak);
		check("wr addr ack", {7'h00, ak}, {7'h00, !acked});
		if (acked) begin
			host_u.xfer_byte(c, 1'b1, rx, ak);
			check("cmd ack", {7'h00, ak}, 8'h00);
			host_u.xfer_byte(v, 1'b1, rx, ak);
			check("data ack", {7'h00, ak}, 8'h00);
		end
		host_u.stop_cond();
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic [7:0] exp);
		host_u.start_cond();
		host_u.xfer_byte({a, 1'b0}, 1'b1, rx, ak);
		host_u.xfer_byte(c, 1'b1, rx, ak);
		host_u.start_cond();
		host_u.xfer_byte({a, RW_READ}, 1'b1, rx, ak);
		host_u.xfer_byte(8'hff, 1'b1, rx, ak);
		host_u.stop_cond();
		check("read byte", rx, exp);
	endtask : rd

	task automatic rcv(input logic [6:0] a, input logic [7:0] tx, input logic acked,
		input logic [7:0] exp);
		host_u.start_cond();
		host_u.xfer_byte({a, RW_READ}, 1'b1, rx, ak);
		check("rd addr ack", {7'h00, ak}, {7'h00, !acked});
		if (acked) begin
			host_u.xfer_byte(tx, 1'b1, rx, ak);
			check("receive byte", rx, exp);
		end
		host_u.stop_cond();
	endtask : rcv

	task automatic pulse(input logic [7:0] v);
		@(posedge i_clk) #1 ev = v;
		@(posedge i_clk) #1 ev = 8'h00;
	endtask : pulse

	task automatic alert_is(input logic exp);
		repeat (10) @(posedge i_clk);
		check("alert", {7'h00, o_alert_oe}, {7'h00, exp});
	endtask : alert_is

	initial begin
		#1_500_000;
		bad_count++;
		report_and_stop();
	end

	initial begin
		bad_count = 0;
		checks = 0;
		void'($urandom(32'h396e_d75a));
		i_nrst = 1'b0;
		ev = 8'h00;
		sel = 4'($urandom);
		own = {OWN_ADDR_HI, sel};
		repeat (20) @(posedge i_clk);
		#1 i_nrst = 1'b1;
		repeat (10) @(posedge i_clk);
		check("data idle", {7'h00, o_serial_data_output}, 8'h00);
		check("alert idle", {7'h00, o_alert_oe}, 8'h00);
		repeat (3) begin
			d = 8'($urandom);
			wr(own, {3'($urandom), REG_PORT_CTRL}, d, 1'b1);
			check("port ctrl", o_port_ctrl, d);
			rd(own, 8'(REG_PORT_CTRL), d);
		end
		d = 8'($urandom);
		wr(BCAST_ADDR, 8'(REG_PORT_CTRL), d, 1'b1);
		check("bcast ctrl", o_port_ctrl, d);
		wr({3'h5, sel}, 8'(REG_PORT_CTRL), ~d, 1'b0);
		check("ctrl kept", o_port_ctrl, d);
		rcv(ARA_ADDR, 8'hff, 1'b0, 8'h00);
		e = 8'($urandom) | 8'h01;
		fork
			wr(own, 8'(REG_MASK), 8'hff, 1'b1);
			begin
				#3000 pulse(e);
				alert_is(1'b0);
			end
		join
		alert_is(1'b1);
		rcv(own, 8'hff, 1'b1, e);
		rcv(ARA_ADDR, 8'h00, 1'b1, 8'h00);
		alert_is(1'b1);
		rcv(ARA_ADDR, 8'hff, 1'b1, ara_reply(sel));
		alert_is(1'b0);
		rcv(own, 8'hff, 1'b1, e);
		alert_is(1'b0);
		wr(own, 8'(REG_IRQ_CLR), 8'h80, 1'b1);
		rcv(own, 8'hff, 1'b1, 8'h00);
		pulse(e);
		alert_is(1'b1);
		wr(own, 8'(REG_IRQ_CLR), 8'h40, 1'b1);
		alert_is(1'b0);
		rd(own, 8'(REG_EVENTS_COR), e);
		rcv(own, 8'hff, 1'b1, 8'h00);
		rd(own, 8'(REG_MASK), 8'hff);
		wr(own, 8'(REG_MASK), 8'hf4, 1'b1);
		rd(own, 8'(REG_MASK), 8'hf4);
		check("ack stable", 8'(host_u.unstable), 8'h00);
		report_and_stop();
	end
endmodule : testbench
